// ---- logic/periodic_timer_regs.svh ----
// Register offsets, field positions and reset values of the periodic timer
`ifndef PERIODIC_TIMER_REGS_SVH
`define PERIODIC_TIMER_REGS_SVH
`define REG_RUN_CLOCK_CONTROL 12'h000
`define REG_MODE_OUTPUT_CONTROL 12'h004
`define REG_COUNTER_LOW 12'h008
`define REG_COUNTER_HIGH 12'h00c
`define REG_COMPARE_A_LOW 12'h010
`define REG_COMPARE_A_HIGH 12'h014
`define REG_PERIOD_LOW 12'h018
`define REG_PERIOD_HIGH 12'h01c
`define REG_STATUS 12'h020
`define BIT_PAUSE 7
`define BIT_ON 3
`define FLD_CLKSEL_HI 6
`define FLD_CLKSEL_LO 4
`define FLD_MODE_HI 7
`define FLD_MODE_LO 6
`define FLD_OUTFN_HI 5
`define FLD_OUTFN_LO 4
`define BIT_INIT_LEVEL 3
`define BIT_INVERT 2
`define BIT_CAPTURE_SRC 1
`define BIT_CLEAR_SEL 0
`define BIT_FLAG_A 0
`define BIT_FLAG_P 1
`define RESET_BYTE 8'h00
`define RESET_COUNT 10'h000
`define COUNT_MAX 10'h3ff
`define DIV_SYS4 4
`define DIV_HIGH16 16
`define DIV_HIGH64 64
`endif

// ---- logic/periodic_timer_pkg.sv ----
// Types shared by the periodic timer
package periodic_timer_pkg;
    typedef enum logic [1:0] {
        MODE_COMPARE_OUT,
        MODE_CAPTURE,
        MODE_PWM_PULSE,
        MODE_TIMER
    } op_mode_e;
    typedef enum logic [2:0] {
        CLK_SYS_DIV4,
        CLK_SYS,
        CLK_HIGH_DIV16,
        CLK_HIGH_DIV64,
        CLK_TIMEBASE,
        CLK_HIGH,
        CLK_PIN_RISE,
        CLK_PIN_FALL
    } clk_sel_e;
endpackage

// ---- logic/pin_sync.sv ----
// Three-stage synchroniser with agreement filter and edge outputs
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Pin and filtered view
    input wire logic pinIn,
    output logic level,
    output logic rise,
    output logic fall
);
    logic [2:0] stage;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stage <= 3'h0;
        end else begin
            stage <= {stage[1:0], pinIn};
        end
    end
    // Change counts once stages two and three agree
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            level <= 1'b0;
        end else if (stage[1] == stage[2]) begin
            level <= stage[2];
        end
    end
    assign rise = (stage[1] == stage[2]) && stage[2] && !level;
    assign fall = (stage[1] == stage[2]) && !stage[2] && level;
endmodule

// ---- logic/periodic_timer.sv ----
// 10-bit periodic timer with APB register access
//
// Behaviour
// - Ten-bit up-counter advancing on the selected internal or external clock.
// - Comparator A checks compare A value; comparator P checks period value.
// - Software cannot write the counter; on-bit rising edge also clears it.
// - Overflow or selected compare match clears counter and raises a request flag.
// - Counter readable as byte pair; two compare values are writable byte pairs.
// - Pause bit freezes counter; clearing it resumes from the held value.
// - Clock select field picks one of eight counting clock sources.
// - On bit lets the counter run; clearing it stops the module.
// - On-bit rise zeroes the counter; on-bit fall keeps the residual value.
// - Compare output mode: on-bit rise returns pin to initial level.
// - Mode field: compare output, capture, PWM or single pulse, timer; PWM/pulse mode has no pulse logic and drives neither pin.
// - Timer/counter mode does not drive the output pins.
// - Unused low three bits of first control register read zero.
// - One or two output pins; first may be internal only.
// - Clear select: 0 period match or overflow at zero period; 1 A match; capture mode always clears on period match or overflow.
// - Output function on A match: none, low, high or toggle.
// - Capture source: 0 timer pin, 1 external clock pin.
// - Clear select low sets both flags; high sets only the A flag, except in capture mode, which still sets the period flag.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "periodic_timer_regs.svh"
module periodic_timer #(
    parameter int COUNT_WIDTH = 10,
    parameter bit SECOND_PIN_ONLY = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Internal clock ticks
    input wire logic highClockTick,
    input wire logic timebaseTick,
    // Pins
    input wire logic externalClockPin,
    input wire logic timerPinFirstIn,
    input wire logic timerPinSecondIn,
    output logic timerPinFirstOut,
    output logic timerPinFirstOe,
    output logic timerPinSecondOut,
    output logic timerPinSecondOe,
    // Events
    output logic compareAFlag,
    output logic periodCompareFlag,
    output logic timerIrq
);
    // ==========================================================
    // Registers
    logic [7:0] runClockControl;
    logic [7:0] modeOutputControl;
    logic [COUNT_WIDTH-1:0] counter;
    logic [COUNT_WIDTH-1:0] compareAValue;
    logic [COUNT_WIDTH-1:0] periodCompareValue;
    logic onPrev;
    logic outLevel;
    logic [5:0] divCount;
    logic [5:0] highDivCount;
    logic [1:0] sysDivCount;
    logic apbWrite;
    logic apbRead;
    logic wrFlag;
    logic captureEdge;
    logic captureLevelPrev;
    logic [7:0] wdata;
    periodic_timer_pkg::op_mode_e opMode;
    periodic_timer_pkg::clk_sel_e clkSel;
    logic counterOn;
    logic paused;
    logic onRise;
    logic tick;
    logic matchA;
    logic matchP;
    logic clearSel;
    logic clearEvent;
    logic overflow;
    logic setFlagA;
    logic setFlagP;
    logic extLevel;
    logic extRise;
    logic extFall;
    logic pinFirstLevel;
    logic pinSecondLevel;
    logic capLevel;
    logic [1:0] outFn;
    logic high16Tick;
    logic high64Tick;
    logic [COUNT_WIDTH-1:0] next_counter;

    assign opMode = periodic_timer_pkg::op_mode_e'(
        modeOutputControl[`FLD_MODE_HI:`FLD_MODE_LO]);
    assign clkSel = periodic_timer_pkg::clk_sel_e'(
        runClockControl[`FLD_CLKSEL_HI:`FLD_CLKSEL_LO]);
    assign counterOn = runClockControl[`BIT_ON];
    assign paused = runClockControl[`BIT_PAUSE];
    assign outFn = modeOutputControl[`FLD_OUTFN_HI:`FLD_OUTFN_LO];
    assign clearSel = modeOutputControl[`BIT_CLEAR_SEL];
    assign onRise = counterOn && !onPrev;
    assign wdata = pwdata[7:0];

    // ==========================================================
    // Pin synchronisers
    pin_sync extSync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pinIn(externalClockPin),
        .level(extLevel),
        .rise(extRise),
        .fall(extFall)
    );
    pin_sync firstSync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pinIn(timerPinFirstIn),
        .level(pinFirstLevel),
        .rise(),
        .fall()
    );
    pin_sync secondSync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pinIn(timerPinSecondIn),
        .level(pinSecondLevel),
        .rise(),
        .fall()
    );

    // ==========================================================
    // Clock source selection
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sysDivCount <= 2'h0;
        end else begin
            sysDivCount <= sysDivCount + 2'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            highDivCount <= 6'h00;
        end else if (highClockTick) begin
            highDivCount <= highDivCount + 6'h01;
        end
    end
    assign high16Tick = highClockTick && (highDivCount[3:0] == 4'(`DIV_HIGH16 - 1));
    assign high64Tick = highClockTick && (highDivCount == 6'(`DIV_HIGH64 - 1));
    always_comb begin
        case (clkSel)
            periodic_timer_pkg::CLK_SYS_DIV4: tick = (sysDivCount == 2'(`DIV_SYS4 - 1));
            periodic_timer_pkg::CLK_SYS: tick = 1'b1;
            periodic_timer_pkg::CLK_HIGH_DIV16: tick = high16Tick;
            periodic_timer_pkg::CLK_HIGH_DIV64: tick = high64Tick;
            periodic_timer_pkg::CLK_TIMEBASE: tick = timebaseTick;
            periodic_timer_pkg::CLK_HIGH: tick = highClockTick;
            periodic_timer_pkg::CLK_PIN_RISE: tick = extRise;
            default: tick = extFall;
        endcase
    end

    // ==========================================================
    // Comparators and counter
    assign matchA = (counter == compareAValue);
    assign matchP = (periodCompareValue != `RESET_COUNT) && (counter == periodCompareValue);
    assign overflow = (periodCompareValue == `RESET_COUNT) && (counter == `COUNT_MAX);
    always_comb begin
        if (opMode == periodic_timer_pkg::MODE_CAPTURE) begin
            clearEvent = matchP || overflow;
        end else if (clearSel) begin
            clearEvent = matchA;
        end else begin
            clearEvent = matchP || overflow;
        end
    end
    always_comb begin
        if (clearEvent) begin
            next_counter = `RESET_COUNT;
        end else begin
            next_counter = counter + 10'h001;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            onPrev <= 1'b0;
        end else begin
            onPrev <= counterOn;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            counter <= `RESET_COUNT;
        end else if (onRise) begin
            counter <= `RESET_COUNT;
        end else if (counterOn && !paused && tick) begin
            counter <= next_counter;
        end
    end

    // ==========================================================
    // Event flags, set wins over clear
    assign captureEdge = (opMode == periodic_timer_pkg::MODE_CAPTURE) && counterOn
        && (outFn != 2'h3) && (capLevel != captureLevelPrev)
        && (outFn == 2'h2 || capLevel == !outFn[0]);
    assign setFlagA = (counterOn && !paused && tick && matchA
        && opMode != periodic_timer_pkg::MODE_CAPTURE) || captureEdge;
    assign setFlagP = counterOn && !paused && tick && (matchP || overflow)
        && (opMode == periodic_timer_pkg::MODE_CAPTURE || !clearSel);
    assign wrFlag = apbWrite && (paddr == `REG_STATUS);
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            compareAFlag <= 1'b0;
        end else if (setFlagA) begin
            compareAFlag <= 1'b1;
        end else if (wrFlag && pwdata[`BIT_FLAG_A]) begin
            compareAFlag <= 1'b0;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            periodCompareFlag <= 1'b0;
        end else if (setFlagP) begin
            periodCompareFlag <= 1'b1;
        end else if (wrFlag && pwdata[`BIT_FLAG_P]) begin
            periodCompareFlag <= 1'b0;
        end
    end
    assign timerIrq = compareAFlag || periodCompareFlag;

    // ==========================================================
    // Capture input
    always_comb begin
        if (modeOutputControl[`BIT_CAPTURE_SRC]) begin
            capLevel = extLevel;
        end else if (SECOND_PIN_ONLY) begin
            capLevel = pinSecondLevel;
        end else begin
            capLevel = pinFirstLevel;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            captureLevelPrev <= 1'b0;
        end else begin
            captureLevelPrev <= capLevel;
        end
    end

    // ==========================================================
    // Output pin
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            outLevel <= 1'b0;
        end else if (onRise && opMode == periodic_timer_pkg::MODE_COMPARE_OUT) begin
            outLevel <= modeOutputControl[`BIT_INIT_LEVEL];
        end else if (setFlagA && opMode == periodic_timer_pkg::MODE_COMPARE_OUT) begin
            case (outFn)
                2'h1: outLevel <= 1'b0;
                2'h2: outLevel <= 1'b1;
                2'h3: outLevel <= !outLevel;
                default: outLevel <= outLevel;
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            timerPinFirstOut <= 1'b0;
            timerPinSecondOut <= 1'b0;
            timerPinFirstOe <= 1'b0;
            timerPinSecondOe <= 1'b0;
        end else begin
            timerPinFirstOut <= outLevel ^ modeOutputControl[`BIT_INVERT];
            timerPinSecondOut <= outLevel ^ modeOutputControl[`BIT_INVERT];
            timerPinFirstOe <= (opMode == periodic_timer_pkg::MODE_COMPARE_OUT)
                && !SECOND_PIN_ONLY;
            timerPinSecondOe <= (opMode == periodic_timer_pkg::MODE_COMPARE_OUT);
        end
    end

    // ==========================================================
    // APB slave
    assign apbWrite = psel && penable && pwrite;
    assign apbRead = psel && penable && !pwrite;
    assign pready = 1'b1;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            runClockControl <= `RESET_BYTE;
            modeOutputControl <= `RESET_BYTE;
            compareAValue <= `RESET_COUNT;
            periodCompareValue <= `RESET_COUNT;
        end else if (apbWrite) begin
            if (paddr == `REG_RUN_CLOCK_CONTROL) begin
                runClockControl <= {wdata[7:3], 3'h0};
            end else if (paddr == `REG_MODE_OUTPUT_CONTROL) begin
                modeOutputControl <= wdata;
            end else if (paddr == `REG_COMPARE_A_LOW) begin
                compareAValue[7:0] <= wdata;
            end else if (paddr == `REG_COMPARE_A_HIGH) begin
                compareAValue[9:8] <= wdata[1:0];
            end else if (paddr == `REG_PERIOD_LOW) begin
                periodCompareValue[7:0] <= wdata;
            end else if (paddr == `REG_PERIOD_HIGH) begin
                periodCompareValue[9:8] <= wdata[1:0];
            end
        end else if (captureEdge) begin
            compareAValue <= counter;
        end
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable) begin
                if (paddr == `REG_RUN_CLOCK_CONTROL) begin
                    prdata <= {24'h000000, runClockControl};
                end else if (paddr == `REG_MODE_OUTPUT_CONTROL) begin
                    prdata <= {24'h000000, modeOutputControl};
                end else if (paddr == `REG_COUNTER_LOW) begin
                    prdata <= {24'h000000, counter[7:0]};
                end else if (paddr == `REG_COUNTER_HIGH) begin
                    prdata <= {30'h00000000, counter[9:8]};
                end else if (paddr == `REG_COMPARE_A_LOW) begin
                    prdata <= {24'h000000, compareAValue[7:0]};
                end else if (paddr == `REG_COMPARE_A_HIGH) begin
                    prdata <= {30'h00000000, compareAValue[9:8]};
                end else if (paddr == `REG_PERIOD_LOW) begin
                    prdata <= {24'h000000, periodCompareValue[7:0]};
                end else if (paddr == `REG_PERIOD_HIGH) begin
                    prdata <= {30'h00000000, periodCompareValue[9:8]};
                end else if (paddr == `REG_STATUS) begin
                    prdata <= {30'h00000000, periodCompareFlag, compareAFlag};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- sim/periodic_timer_assertions.sv ----
// Checker for the periodic timer ports
`timescale 1ns/1ps
module periodic_timer_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Pins and events
    input wire logic timerPinSecondOut,
    input wire logic timerPinFirstOe,
    input wire logic timerPinSecondOe,
    input wire logic compareAFlag,
    input wire logic periodCompareFlag,
    input wire logic timerIrq
);
    logic [7:0] runCtrl;
    logic [7:0] modeCtrl;
    logic [1:0] timerAge;
    logic wr;
    logic rd;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ==========
    // Shadow control bytes
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            runCtrl <= 8'h00;
            modeCtrl <= 8'h00;
        end else if (wr && paddr == 12'h000) begin
            runCtrl <= pwdata[7:0];
        end else if (wr && paddr == 12'h004) begin
            modeCtrl <= pwdata[7:0];
        end
    end
    // Cycles spent in timer mode
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            timerAge <= 2'h0;
        end else if (modeCtrl[7:6] != 2'b11) begin
            timerAge <= 2'h0;
        end else if (timerAge != 2'h3) begin
            timerAge <= timerAge + 2'h1;
        end
    end
    // ==========
    // Assertions
    AST_IRQ_JOIN: assert property (timerIrq == (compareAFlag || periodCompareFlag))
        else $error("irq differs from flags");
    AST_RUN_READ: assert property (rd && paddr == 12'h000 |-> prdata[7:0] == (runCtrl & 8'hf8))
        else $error("run control readback wrong");
    AST_MODE_READ: assert property (rd && paddr == 12'h004 |-> prdata[7:0] == modeCtrl)
        else $error("mode control readback wrong");
    AST_HIGH_BYTES: assert property (rd && paddr inside {12'h00c, 12'h014, 12'h01c}
        |-> prdata[7:2] == 6'h00)
        else $error("high byte upper bits set");
    AST_UNMAPPED: assert property (psel && !penable && paddr > 12'h020 |=> pslverr)
        else $error("no error on unmapped access");
    AST_TIMER_QUIET: assert property (timerAge == 2'h3 |-> !timerPinFirstOe && !timerPinSecondOe)
        else $error("pin driven in timer mode");
    AST_INIT_LEVEL: assert property (wr && paddr == 12'h000 && pwdata[3] && !runCtrl[3]
        && modeCtrl[7:6] == 2'b00 |-> ##[2:4] timerPinSecondOut == (modeCtrl[3] ^ modeCtrl[2]))
        else $error("pin not at initial level");
    AST_FLAG_HOLD: assert property ($fell(compareAFlag)
        |-> $past(wr && paddr == 12'h020 && pwdata[0]))
        else $error("flag dropped without clear");
    AST_P_SILENT: assert property ($rose(periodCompareFlag) && modeCtrl[7] == modeCtrl[6]
        |-> !modeCtrl[0])
        else $error("period flag with clear select high");
    cover property ($rose(compareAFlag));
    cover property ($rose(periodCompareFlag));
    cover property ($changed(timerPinSecondOut));
endmodule

bind periodic_timer periodic_timer_checker CHK (.clk_sys, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pslverr, .timerPinSecondOut, .timerPinFirstOe,
    .timerPinSecondOe, .compareAFlag, .periodCompareFlag, .timerIrq);

// ---- sim/timer_pin_partner.sv ----
// Model of the pins facing the timer
`timescale 1ns/1ps
module timer_pin_partner (
    // Clock
    input wire logic clk_sys,
    // Pins into the timer
    output logic extClock,
    output logic pinFirst
);
    initial begin
        extClock = 1'b0;
        pinFirst = 1'b0;
    end
    // Full pulses on the external clock pin
    task automatic clock_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            extClock <= 1'b1;
            repeat (6) @(posedge clk_sys);
            extClock <= 1'b0;
            repeat (6) @(posedge clk_sys);
        end
    endtask
    // One rising edge on a capture source
    task automatic capture_edge(input bit onClock);
        if (onClock) begin
            extClock <= 1'b1;
        end else begin
            pinFirst <= 1'b1;
        end
        repeat (8) @(posedge clk_sys);
        extClock <= 1'b0;
        pinFirst <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the periodic timer
`timescale 1ns/1ps
`include "periodic_timer_regs.svh"
module tb_top;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic highClockTick = 1'b0;
    logic timebaseTick = 1'b0;
    logic pinSecond = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, extClock, pinFirst;
    logic firstOut, firstOe, secondOut, secondOe, flagA, flagP, irq;
    logic [7:0] rdByte, held;
    logic busErr;
    logic [2:0] selTab [6] = '{3'h4, 3'h5, 3'h2, 3'h3, 3'h6, 3'h7};
    int tickTab [6] = '{5, 5, 32, 128, 3, 3};
    logic [7:0] cntTab [6] = '{8'h05, 8'h05, 8'h02, 8'h02, 8'h03, 8'h03};
    logic initTab [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic pinTab [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    always #2.5 clk_sys = ~clk_sys;
    periodic_timer DUT (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .highClockTick, .timebaseTick,
        .externalClockPin(extClock), .timerPinFirstIn(pinFirst), .timerPinSecondIn(pinSecond),
        .timerPinFirstOut(firstOut), .timerPinFirstOe(firstOe), .timerPinSecondOut(secondOut),
        .timerPinSecondOe(secondOe), .compareAFlag(flagA), .periodCompareFlag(flagP),
        .timerIrq(irq));
    timer_pin_partner PARTNER (.clk_sys, .extClock, .pinFirst);
    // ==========
    // Tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rdByte = prdata[7:0];
        busErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd_check(input string what, input logic [11:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(what, rdByte, exp);
    endtask
    task automatic ticks(input bit high, input int n);
        repeat (n) begin
            highClockTick <= high;
            timebaseTick <= !high;
            @(posedge clk_sys);
            highClockTick <= 1'b0;
            timebaseTick <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    task automatic wrap_up();
        $display("Checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    // ==========
    // Scenarios
    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            rd_check("reset value", 12'(4 * i), 8'h00);
        end
        bus(1'b0, 12'h040, 8'h00);
        check("unmapped", {7'h0, busErr}, 8'h01);
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'hff);
        rd_check("run control", `REG_RUN_CLOCK_CONTROL, 8'hf8);
        // Free run, pause, off, on
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h18);
        repeat (20) @(posedge clk_sys);
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h98);
        bus(1'b0, `REG_COUNTER_LOW, 8'h00);
        held = rdByte;
        check("counting", {7'h0, held != 8'h00}, 8'h01);
        repeat (10) @(posedge clk_sys);
        rd_check("paused count", `REG_COUNTER_LOW, held);
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h18);
        repeat (10) @(posedge clk_sys);
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h10);
        bus(1'b0, `REG_COUNTER_LOW, 8'h00);
        check("resumed", {7'h0, rdByte > held}, 8'h01);
        held = rdByte;
        repeat (10) @(posedge clk_sys);
        rd_check("off count", `REG_COUNTER_LOW, held);
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h48);
        bus(1'b1, `REG_COUNTER_LOW, 8'h55);
        rd_check("on clears", `REG_COUNTER_LOW, 8'h00);
        // Clock sources
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h00);
            bus(1'b1, `REG_RUN_CLOCK_CONTROL, {1'b0, selTab[i], 4'h8});
            if (selTab[i] >= 3'h6) begin
                PARTNER.clock_pulses(tickTab[i]);
            end else begin
                ticks(selTab[i] != 3'h4, tickTab[i]);
            end
            repeat (8) @(posedge clk_sys);
            rd_check("clock select", `REG_COUNTER_LOW, cntTab[i]);
        end
        // System clock over four
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h00);
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h08);
        repeat (40) @(posedge clk_sys);
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h00);
        bus(1'b0, `REG_COUNTER_LOW, 8'h00);
        check("system div4", {7'h0, rdByte inside {8'h0a, 8'h0b}}, 8'h01);
        // Period clear, then compare A clear
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h00);
        bus(1'b1, `REG_COMPARE_A_LOW, 8'h03);
        bus(1'b1, `REG_STATUS, 8'h03);
        bus(1'b1, `REG_PERIOD_LOW, 8'h05);
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h48);
        ticks(1'b0, 6);
        rd_check("period clear", `REG_COUNTER_LOW, 8'h00);
        rd_check("both flags", `REG_STATUS, 8'h03);
        check("irq", {7'h0, irq}, 8'h01);
        check("flag pins", {6'h0, flagP, flagA}, 8'h03);
        bus(1'b1, `REG_STATUS, 8'h03);
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h00);
        bus(1'b1, `REG_PERIOD_LOW, 8'h02);
        bus(1'b1, `REG_MODE_OUTPUT_CONTROL, 8'h01);
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h48);
        ticks(1'b0, 4);
        rd_check("compare clear", `REG_COUNTER_LOW, 8'h00);
        rd_check("only A flag", `REG_STATUS, 8'h01);
        // Overflow with zero period
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h00);
        bus(1'b1, `REG_MODE_OUTPUT_CONTROL, 8'h00);
        bus(1'b1, `REG_PERIOD_LOW, 8'h00);
        bus(1'b1, `REG_STATUS, 8'h03);
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h18);
        repeat (1100) @(posedge clk_sys);
        rd_check("overflow flag", `REG_STATUS, 8'h03);
        // Output functions
        bus(1'b1, `REG_COMPARE_A_LOW, 8'h02);
        for (int f = 0; f < 4; f++) begin
            bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h00);
            bus(1'b1, `REG_MODE_OUTPUT_CONTROL, {2'b00, 2'(f), initTab[f], 1'(f == 3), 2'h0});
            bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h48);
            repeat (3) @(posedge clk_sys);
            check("initial level", {7'h0, secondOut}, {7'h0, initTab[f] ^ 1'(f == 3)});
            check("first pin", {7'h0, firstOe}, 8'h01);
            ticks(1'b0, 3);
            repeat (3) @(posedge clk_sys);
            check("match output", {7'h0, secondOut}, {7'h0, pinTab[f] ^ 1'(f == 3)});
            check("first out", {7'h0, firstOut}, {7'h0, pinTab[f] ^ 1'(f == 3)});
        end
        // Timer mode
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h00);
        bus(1'b1, `REG_MODE_OUTPUT_CONTROL, 8'hc0);
        bus(1'b1, `REG_STATUS, 8'h03);
        bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h48);
        ticks(1'b0, 3);
        check("timer pins", {6'h0, firstOe, secondOe}, 8'h00);
        rd_check("timer flag", `REG_STATUS, 8'h01);
        // Capture from both sources
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h00);
            bus(1'b1, `REG_MODE_OUTPUT_CONTROL, {6'h10, 1'(s), 1'b0});
            bus(1'b1, `REG_STATUS, 8'h03);
            bus(1'b1, `REG_RUN_CLOCK_CONTROL, 8'h48);
            ticks(1'b0, 7 + s);
            PARTNER.capture_edge(1'(s));
            rd_check("captured", `REG_COMPARE_A_LOW, 8'(7 + s));
            rd_check("capture flag", `REG_STATUS, 8'h01);
        end
        wrap_up();
    end
endmodule
